// ### hw/pll_cfg_pkg.sv
// pll_cfg_pkg: offsets, reset values, field positions and frame layout
// for the converter clock-multiplier configuration bank.
// assumes one byte-wide register per address on the serial control port.
package pll_cfg_pkg;

    // serial frame: one read/write bit, 15 address bits, then 8 data bits
    localparam int INSTR_BITS = 16;
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS = 15;
    localparam int CNT_BITS = 5;
    localparam int RW_BIT = 15;
    localparam logic [4:0] INSTR_LAST = 5'h0F;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] FRAME_DONE = 5'h18;

    // register byte addresses
    localparam logic [14:0] ADDR_INT_DIV = 15'h0085;
    localparam logic [14:0] ADDR_FILT1 = 15'h0087;
    localparam logic [14:0] ADDR_FILT2 = 15'h0088;
    localparam logic [14:0] ADDR_FILT3 = 15'h0089;
    localparam logic [14:0] ADDR_PUMP = 15'h008A;
    localparam logic [14:0] ADDR_ODIV = 15'h008B;

    // reset values
    localparam logic [7:0] RST_INT_DIV = 8'h08;
    localparam logic [7:0] RST_FILT1 = 8'h88;
    localparam logic [7:0] RST_FILT2 = 8'h88;
    localparam logic [7:0] RST_FILT3 = 8'h08;
    localparam logic [5:0] RST_PUMP = 6'h20;
    localparam logic [1:0] RST_ODIV = 2'h2;

    // field positions
    localparam int NIB_HI_MSB = 7;
    localparam int NIB_HI_LSB = 4;
    localparam int NIB_LO_MSB = 3;
    localparam int NIB_LO_LSB = 0;
    localparam int BYP_RES_THREE = 7;
    localparam int BYP_RES_ONE = 6;
    localparam int BYP_CAP_TWO = 5;
    localparam int BYP_CAP_ONE = 4;
    localparam int PUMP_MSB = 5;
    localparam int ODIV_MSB = 1;

    // integer divider floor and output divider codes and ratios
    localparam logic [7:0] MIN_INT_DIV = 8'h06;
    localparam logic [1:0] ODIV_BY4 = 2'h1;
    localparam logic [1:0] ODIV_BY8 = 2'h2;
    localparam logic [1:0] ODIV_BY16 = 2'h3;
    localparam logic [4:0] RATIO_4 = 5'h04;
    localparam logic [4:0] RATIO_8 = 5'h08;
    localparam logic [4:0] RATIO_16 = 5'h10;
    localparam logic [4:0] RATIO_NONE = 5'h00;
    localparam logic [3:0] NIB_ZERO = 4'h0;

endpackage

// ### hw/pin_sync.sv
// pin_sync: two-flop synchroniser for one asynchronous pin.
// assumes the pin may change at any time relative to the clock.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_in, // sampling clock
    input wire logic rst_in, // async reset, active high
    input wire logic ce_in, // clock enable, freezes when low
    input wire logic pin_in, // asynchronous pin level
    output logic sync_out // level after two flops
);
    logic meta_q;
    logic sync_q;

    // first flop feeds only the second one
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else if (ce_in) begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### hw/converter_pll_config_regs.sv
// converter_pll_config_regs: byte-wide configuration bank for the
// converter clock-multiplying loop, written and read over a 4-wire
// serial control port sampled on ref_clk_in.
// assumes sclk high and low phases each last at least 3 ref_clk periods.
`timescale 1ns/1ns
`default_nettype none
module converter_pll_config_regs (
    input wire logic ref_clk_in, // 10 MHz block clock
    input wire logic rst_in, // async reset, active high
    input wire logic ce_in, // clock enable, freezes all state when low
    input wire logic spi_sclk_in, // serial clock pin
    input wire logic spi_csb_in, // serial chip select pin, active low
    input wire logic spi_sdi_in, // serial data in pin
    output logic spi_sdo_out, // serial data out
    output logic spi_sdo_oe_out, // high while sdo is driven
    output logic [7:0] feedback_word_out, // integer feedback divider
    output logic feedback_word_low_out, // divider word below minimum
    output logic [3:0] filter_cap_two_word_out, // second capacitor word
    output logic [3:0] filter_cap_one_word_out, // first capacitor word
    output logic [3:0] filter_res_one_word_out, // first resistor word
    output logic [3:0] filter_cap_three_word_out, // third capacitor word
    output logic [3:0] filter_res_three_word_out, // third resistor word
    output logic bypass_res_three_out, // third resistor shorted
    output logic bypass_res_one_out, // first resistor shorted
    output logic bypass_cap_two_out, // second capacitor shorted
    output logic bypass_cap_one_out, // first capacitor shorted
    output logic [5:0] pump_current_word_out, // charge-pump current
    output logic [1:0] osc_output_divider_out, // output divider code
    output logic [4:0] osc_divide_ratio_out // decoded ratio, 0 if code 00
);
    typedef enum logic [1:0] {
        ph_instr,
        ph_data,
        ph_over
    } phase_t;

    logic sclk_s;
    logic csb_s;
    logic sdi_s;

    // pins cross into the clock domain before anything reads them
    pin_sync #(.RESET_VAL(1'b0)) sync_sclk (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .pin_in(spi_sclk_in),
        .sync_out(sclk_s)
    );
    pin_sync #(.RESET_VAL(1'b1)) sync_csb (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .pin_in(spi_csb_in),
        .sync_out(csb_s)
    );
    pin_sync #(.RESET_VAL(1'b0)) sync_sdi (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .pin_in(spi_sdi_in),
        .sync_out(sdi_s)
    );

    // readback with reserved bits forced to zero
    function automatic logic [7:0] read_word(input logic [14:0] addr,
                                             input logic [7:0] int_div,
                                             input logic [7:0] filt1,
                                             input logic [7:0] filt2,
                                             input logic [7:0] filt3,
                                             input logic [5:0] pump,
                                             input logic [1:0] odiv);
        logic [7:0] word;
        word = 8'h00;
        case (addr)
            pll_cfg_pkg::ADDR_INT_DIV: word = int_div;
            pll_cfg_pkg::ADDR_FILT1: word = filt1;
            pll_cfg_pkg::ADDR_FILT2: word = filt2;
            pll_cfg_pkg::ADDR_FILT3: word = filt3;
            pll_cfg_pkg::ADDR_PUMP: word = {2'h0, pump};
            pll_cfg_pkg::ADDR_ODIV: word = {6'h00, odiv};
            default: word = 8'h00;
        endcase
        return word;
    endfunction

    // bank state, declared here because the frame engine reads it back
    logic [7:0] int_div_q, int_div_d;
    logic [7:0] filt1_q, filt1_d;
    logic [7:0] filt2_q, filt2_d;
    logic [7:0] filt3_q, filt3_d;
    logic [5:0] pump_q, pump_d;
    logic [1:0] odiv_q, odiv_d;
    logic word_low_q, word_low_d;
    logic [4:0] ratio_q, ratio_d;
    logic [3:0] byp_q, byp_d;
    logic sclk_prev_q, sclk_prev_d;
    phase_t phase_q, phase_d;
    logic [4:0] cnt_q, cnt_d;
    logic [14:0] shift_q, shift_d;
    logic [14:0] addr_q, addr_d;
    logic rd_q, rd_d;
    logic [7:0] out_q, out_d;
    logic sdo_q, sdo_d;
    logic sdo_oe_q, sdo_oe_d;
    logic wr_fire;
    logic [7:0] wr_data;
    logic sclk_rise;
    logic sclk_fall;

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;

    // serial frame engine: bits in on rising sclk, out on falling sclk;
    // one byte per frame, extra bits before csb rises are ignored
    always_comb begin
        sclk_prev_d = sclk_s;
        phase_d = phase_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        addr_d = addr_q;
        rd_d = rd_q;
        out_d = out_q;
        sdo_d = sdo_q;
        sdo_oe_d = sdo_oe_q;
        wr_fire = 1'b0;
        wr_data = {shift_q[6:0], sdi_s};
        if (csb_s) begin
            phase_d = ph_instr;
            cnt_d = 5'h00;
            sdo_oe_d = 1'b0;
        end else if (sclk_rise) begin
            shift_d = {shift_q[13:0], sdi_s};
            case (phase_q)
                ph_instr: begin
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == pll_cfg_pkg::INSTR_LAST) begin
                        rd_d = shift_q[pll_cfg_pkg::RW_BIT - 1];
                        addr_d = {shift_q[13:0], sdi_s};
                        out_d = read_word({shift_q[13:0], sdi_s},
                                          int_div_q, filt1_q, filt2_q,
                                          filt3_q, pump_q, odiv_q);
                        phase_d = ph_data;
                    end
                end
                ph_data: begin
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == pll_cfg_pkg::FRAME_LAST) begin
                        wr_fire = ~rd_q;
                        phase_d = ph_over;
                    end
                end
                ph_over: cnt_d = cnt_q;
                default: phase_d = ph_instr;
            endcase
        end else if (sclk_fall && rd_q) begin
            // drive the next read bit only while data bits remain
            if (phase_q == ph_data) begin
                sdo_d = out_q[7];
                out_d = {out_q[6:0], 1'b0};
                sdo_oe_d = 1'b1;
            end else if (phase_q == ph_over) begin
                sdo_oe_d = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_prev_q <= 1'b0;
            phase_q <= ph_instr;
            cnt_q <= 5'h00;
            shift_q <= 15'h0000;
            addr_q <= 15'h0000;
            rd_q <= 1'b0;
            out_q <= 8'h00;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else if (ce_in) begin
            sclk_prev_q <= sclk_prev_d;
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            out_q <= out_d;
            sdo_q <= sdo_d;
            sdo_oe_q <= sdo_oe_d;
        end
    end

    // register writes; reserved bits are dropped so they stay zero
    always_comb begin
        int_div_d = int_div_q;
        filt1_d = filt1_q;
        filt2_d = filt2_q;
        filt3_d = filt3_q;
        pump_d = pump_q;
        odiv_d = odiv_q;
        if (wr_fire) begin
            case (addr_q)
                pll_cfg_pkg::ADDR_INT_DIV: int_div_d = wr_data;
                pll_cfg_pkg::ADDR_FILT1: filt1_d = wr_data;
                pll_cfg_pkg::ADDR_FILT2: filt2_d = wr_data;
                pll_cfg_pkg::ADDR_FILT3: filt3_d = wr_data;
                pll_cfg_pkg::ADDR_PUMP:
                    pump_d = wr_data[pll_cfg_pkg::PUMP_MSB:0];
                pll_cfg_pkg::ADDR_ODIV:
                    odiv_d = wr_data[pll_cfg_pkg::ODIV_MSB:0];
                default: int_div_d = int_div_q;
            endcase
        end
        // words below the floor are kept but flagged, the loop may misbehave
        word_low_d = int_div_d < pll_cfg_pkg::MIN_INT_DIV;
        case (odiv_d)
            pll_cfg_pkg::ODIV_BY4: ratio_d = pll_cfg_pkg::RATIO_4;
            pll_cfg_pkg::ODIV_BY8: ratio_d = pll_cfg_pkg::RATIO_8;
            pll_cfg_pkg::ODIV_BY16: ratio_d = pll_cfg_pkg::RATIO_16;
            default: ratio_d = pll_cfg_pkg::RATIO_NONE;
        endcase
        // a bypass only takes effect when its element word is zero
        byp_d[3] = filt3_d[pll_cfg_pkg::BYP_RES_THREE] &&
            filt3_d[pll_cfg_pkg::NIB_LO_MSB:pll_cfg_pkg::NIB_LO_LSB] ==
            pll_cfg_pkg::NIB_ZERO;
        byp_d[2] = filt3_d[pll_cfg_pkg::BYP_RES_ONE] &&
            filt2_d[pll_cfg_pkg::NIB_HI_MSB:pll_cfg_pkg::NIB_HI_LSB] ==
            pll_cfg_pkg::NIB_ZERO;
        byp_d[1] = filt3_d[pll_cfg_pkg::BYP_CAP_TWO] &&
            filt1_d[pll_cfg_pkg::NIB_HI_MSB:pll_cfg_pkg::NIB_HI_LSB] ==
            pll_cfg_pkg::NIB_ZERO;
        byp_d[0] = filt3_d[pll_cfg_pkg::BYP_CAP_ONE] &&
            filt1_d[pll_cfg_pkg::NIB_LO_MSB:pll_cfg_pkg::NIB_LO_LSB] ==
            pll_cfg_pkg::NIB_ZERO;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            int_div_q <= pll_cfg_pkg::RST_INT_DIV;
            filt1_q <= pll_cfg_pkg::RST_FILT1;
            filt2_q <= pll_cfg_pkg::RST_FILT2;
            filt3_q <= pll_cfg_pkg::RST_FILT3;
            pump_q <= pll_cfg_pkg::RST_PUMP;
            odiv_q <= pll_cfg_pkg::RST_ODIV;
            word_low_q <= 1'b0;
            ratio_q <= pll_cfg_pkg::RATIO_8;
            byp_q <= 4'h0;
        end else if (ce_in) begin
            int_div_q <= int_div_d;
            filt1_q <= filt1_d;
            filt2_q <= filt2_d;
            filt3_q <= filt3_d;
            pump_q <= pump_d;
            odiv_q <= odiv_d;
            word_low_q <= word_low_d;
            ratio_q <= ratio_d;
            byp_q <= byp_d;
        end
    end

    // outputs, each straight from a flop
    assign spi_sdo_out = sdo_q;
    assign spi_sdo_oe_out = sdo_oe_q;
    assign feedback_word_out = int_div_q;
    assign feedback_word_low_out = word_low_q;
    assign filter_cap_two_word_out =
        filt1_q[pll_cfg_pkg::NIB_HI_MSB:pll_cfg_pkg::NIB_HI_LSB];
    assign filter_cap_one_word_out =
        filt1_q[pll_cfg_pkg::NIB_LO_MSB:pll_cfg_pkg::NIB_LO_LSB];
    assign filter_res_one_word_out =
        filt2_q[pll_cfg_pkg::NIB_HI_MSB:pll_cfg_pkg::NIB_HI_LSB];
    assign filter_cap_three_word_out =
        filt2_q[pll_cfg_pkg::NIB_LO_MSB:pll_cfg_pkg::NIB_LO_LSB];
    assign filter_res_three_word_out =
        filt3_q[pll_cfg_pkg::NIB_LO_MSB:pll_cfg_pkg::NIB_LO_LSB];
    assign bypass_res_three_out = byp_q[3];
    assign bypass_res_one_out = byp_q[2];
    assign bypass_cap_two_out = byp_q[1];
    assign bypass_cap_one_out = byp_q[0];
    assign pump_current_word_out = pump_q;
    assign osc_output_divider_out = odiv_q;
    assign osc_divide_ratio_out = ratio_q;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    int_div_write_a: assert property (
        ce_in && wr_fire && addr_q == pll_cfg_pkg::ADDR_INT_DIV
        |=> int_div_q == $past(wr_data))
        else $error("integer divider write lost");
    word_low_flag_a: assert property (
        word_low_q == (int_div_q < pll_cfg_pkg::MIN_INT_DIV))
        else $error("divider floor flag wrong");
    ratio_decode_a: assert property (
        ratio_q == (odiv_q == pll_cfg_pkg::ODIV_BY4 ? pll_cfg_pkg::RATIO_4 :
                    odiv_q == pll_cfg_pkg::ODIV_BY8 ? pll_cfg_pkg::RATIO_8 :
                    odiv_q == pll_cfg_pkg::ODIV_BY16 ? pll_cfg_pkg::RATIO_16 :
                    pll_cfg_pkg::RATIO_NONE))
        else $error("output divider ratio wrong");
    filt1_write_a: assert property (
        ce_in && wr_fire && addr_q == pll_cfg_pkg::ADDR_FILT1
        |=> filt1_q == $past(wr_data))
        else $error("first filter write lost");
    filt2_write_a: assert property (
        ce_in && wr_fire && addr_q == pll_cfg_pkg::ADDR_FILT2
        |=> filt2_q == $past(wr_data))
        else $error("second filter write lost");
    bypass_effect_a: assert property (
        bypass_res_three_out == (filt3_q[pll_cfg_pkg::BYP_RES_THREE] &&
            filter_res_three_word_out == pll_cfg_pkg::NIB_ZERO) &&
        bypass_cap_one_out == (filt3_q[pll_cfg_pkg::BYP_CAP_ONE] &&
            filter_cap_one_word_out == pll_cfg_pkg::NIB_ZERO))
        else $error("bypass does not follow word");
    pump_write_a: assert property (
        ce_in && wr_fire && addr_q == pll_cfg_pkg::ADDR_PUMP
        |=> pump_q == $past(wr_data[5:0]))
        else $error("pump current write lost");
    hold_no_write_a: assert property (
        ce_in && !wr_fire |=> $stable(int_div_q) && $stable(pump_q))
        else $error("register changed without a write");
    enable_freeze_a: assert property (
        !ce_in |=> $stable(cnt_q) && $stable(odiv_q))
        else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// ### dv/converter_pll_config_regs_test.sv
// converter_pll_config_regs_test: self-checking bench for the loop
// configuration bank, driving the 4-wire serial port directly.
// assumes pll_cfg_pkg is compiled first; ce_in drops low for one frame.
`timescale 1ns/1ns
`default_nettype none
module converter_pll_config_regs_test;
    logic ref_clk_in, rst_in, ce_in, spi_sclk_in, spi_csb_in, spi_sdi_in;
    logic spi_sdo_out, spi_sdo_oe_out, feedback_word_low_out;
    logic [7:0] feedback_word_out;
    logic [3:0] cap_two, cap_one, res_one, cap_three, res_three;
    logic byp_r3, byp_r1, byp_c2, byp_c1;
    logic [5:0] pump_current_word_out;
    logic [1:0] osc_output_divider_out;
    logic [4:0] osc_divide_ratio_out;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    int i;
    logic [31:0] seed = 32'hEEAA9EDE;
    logic [31:0] r;
    logic [7:0] m_int, m_f1, m_f2, m_f3, m_pump, m_odiv, q;
    logic [14:0] addrs [7];

    converter_pll_config_regs dut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .spi_sclk_in(spi_sclk_in), .spi_csb_in(spi_csb_in),
        .spi_sdi_in(spi_sdi_in), .spi_sdo_out(spi_sdo_out),
        .spi_sdo_oe_out(spi_sdo_oe_out),
        .feedback_word_out(feedback_word_out),
        .feedback_word_low_out(feedback_word_low_out),
        .filter_cap_two_word_out(cap_two), .filter_cap_one_word_out(cap_one),
        .filter_res_one_word_out(res_one),
        .filter_cap_three_word_out(cap_three),
        .filter_res_three_word_out(res_three),
        .bypass_res_three_out(byp_r3), .bypass_res_one_out(byp_r1),
        .bypass_cap_two_out(byp_c2), .bypass_cap_one_out(byp_c1),
        .pump_current_word_out(pump_current_word_out),
        .osc_output_divider_out(osc_output_divider_out),
        .osc_divide_ratio_out(osc_divide_ratio_out)
    );

    // 10 MHz block clock
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    // hang guard: a full run needs about 30000 cycles
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            $display("BAD t=%0t run did not finish in time", $time);
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("mismatches %0d, comparisons %0d", error_cnt,
                 samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // inputs always move 10 ns after the rising edge
    task automatic wait_clk(input int n);
        repeat (n) begin
            @(posedge ref_clk_in);
            #10;
        end
    endtask

    // reference model of the bank: reserved bits never stored
    task automatic model_reset();
        m_int = 8'h08;
        m_f1 = 8'h88;
        m_f2 = 8'h88;
        m_f3 = 8'h08;
        m_pump = 8'h20;
        m_odiv = 8'h02;
    endtask

    task automatic model_write(input logic [14:0] a, input logic [7:0] d);
        case (a)
            pll_cfg_pkg::ADDR_INT_DIV: m_int = d;
            pll_cfg_pkg::ADDR_FILT1: m_f1 = d;
            pll_cfg_pkg::ADDR_FILT2: m_f2 = d;
            pll_cfg_pkg::ADDR_FILT3: m_f3 = {d[7:4], 4'h0} | {4'h0, d[3:0]};
            pll_cfg_pkg::ADDR_PUMP: m_pump = {2'h0, d[5:0]};
            pll_cfg_pkg::ADDR_ODIV: m_odiv = {6'h00, d[1:0]};
            default: ;
        endcase
    endtask

    function automatic logic [7:0] model_read(input logic [14:0] a);
        case (a)
            pll_cfg_pkg::ADDR_INT_DIV: return m_int;
            pll_cfg_pkg::ADDR_FILT1: return m_f1;
            pll_cfg_pkg::ADDR_FILT2: return m_f2;
            pll_cfg_pkg::ADDR_FILT3: return m_f3;
            pll_cfg_pkg::ADDR_PUMP: return m_pump;
            pll_cfg_pkg::ADDR_ODIV: return m_odiv;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] model_ratio();
        case (m_odiv[1:0])
            2'h1: return 8'h04;
            2'h2: return 8'h08;
            2'h3: return 8'h10;
            default: return 8'h00;
        endcase
    endfunction

    // one frame; sclk phases of 6 cycles keep clear of the synchroniser
    // delay, and sdo is sampled just before each rising sclk of the 8 data bits
    task automatic frame(input logic rd_bit, input logic [14:0] a,
                         input logic [7:0] d, input int nbits);
        logic [23:0] f;
        int k;
        f = {rd_bit, a, d};
        q = 8'h00;
        spi_csb_in = 1'b0;
        wait_clk(6);
        for (k = 0; k < nbits; k++) begin
            spi_sdi_in = f[23-k];
            wait_clk(6);
            if (k >= 16)
                q = {q[6:0], spi_sdo_out};
            check({7'h00, spi_sdo_oe_out},
                  {7'h00, rd_bit && k >= 16});
            spi_sclk_in = 1'b1;
            wait_clk(6);
            spi_sclk_in = 1'b0;
        end
        wait_clk(6);
        spi_csb_in = 1'b1;
        spi_sdi_in = ~spi_sdi_in;
        wait_clk(6);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        frame(1'b0, a, d, 24);
        model_write(a, d);
    endtask

    task automatic rd_chk(input logic [14:0] a);
        frame(1'b1, a, 8'h00, 24);
        check(q, model_read(a));
    endtask

    task automatic read_all();
        foreach (addrs[k])
            rd_chk(addrs[k]);
    endtask

    task automatic check_outputs();
        check(feedback_word_out, m_int);
        check({7'h00, feedback_word_low_out}, {7'h00, m_int < 8'h06});
        check({4'h0, cap_two}, {4'h0, m_f1[7:4]});
        check({4'h0, cap_one}, {4'h0, m_f1[3:0]});
        check({4'h0, res_one}, {4'h0, m_f2[7:4]});
        check({4'h0, cap_three}, {4'h0, m_f2[3:0]});
        check({4'h0, res_three}, {4'h0, m_f3[3:0]});
        check({4'h0, byp_r3, byp_r1, byp_c2, byp_c1},
              {4'h0, m_f3[7] && m_f3[3:0] == 4'h0,
               m_f3[6] && m_f2[7:4] == 4'h0,
               m_f3[5] && m_f1[7:4] == 4'h0,
               m_f3[4] && m_f1[3:0] == 4'h0});
        check({2'h0, pump_current_word_out}, m_pump);
        check({6'h00, osc_output_divider_out}, m_odiv);
        check({3'h0, osc_divide_ratio_out}, model_ratio());
    endtask

    initial begin
        addrs = '{pll_cfg_pkg::ADDR_INT_DIV, pll_cfg_pkg::ADDR_FILT1,
                  pll_cfg_pkg::ADDR_FILT2, pll_cfg_pkg::ADDR_FILT3,
                  pll_cfg_pkg::ADDR_PUMP, pll_cfg_pkg::ADDR_ODIV, 15'h0086};
        rst_in = 1'b1;
        ce_in = 1'b1;
        spi_sclk_in = 1'b0;
        spi_csb_in = 1'b1;
        spi_sdi_in = 1'b0;
        model_reset();
        wait_clk(10);
        rst_in = 1'b0;
        wait_clk(4);
        // defaults after reset, by outputs and by readback
        check_outputs();
        read_all();
        // recommended loop settings, for a 40 MHz loop reference
        wr(pll_cfg_pkg::ADDR_INT_DIV, 8'h10); // vco 10.24 GHz
        wr(pll_cfg_pkg::ADDR_FILT1, 8'h62);
        wr(pll_cfg_pkg::ADDR_FILT2, 8'hC9);
        wr(pll_cfg_pkg::ADDR_FILT3, 8'h0E);
        wr(pll_cfg_pkg::ADDR_PUMP, 8'h12);
        check_outputs();
        read_all();
        // every divider code, reserved bits set in the write
        for (i = 0; i < 4; i++) begin
            wr(pll_cfg_pkg::ADDR_ODIV, 8'hFC | 8'(i));
            check_outputs();
            rd_chk(pll_cfg_pkg::ADDR_ODIV);
        end
        // divider word around its floor
        wr(pll_cfg_pkg::ADDR_INT_DIV, 8'h05);
        check_outputs();
        wr(pll_cfg_pkg::ADDR_INT_DIV, 8'h06);
        check_outputs();
        // bypass needs both the bit and a zero word
        wr(pll_cfg_pkg::ADDR_FILT1, 8'h00);
        wr(pll_cfg_pkg::ADDR_FILT2, 8'h00);
        wr(pll_cfg_pkg::ADDR_FILT3, 8'hF0);
        check_outputs();
        wr(pll_cfg_pkg::ADDR_FILT3, 8'hF1);
        wr(pll_cfg_pkg::ADDR_FILT1, 8'h10);
        check_outputs();
        // reserved bits and an unmapped byte
        wr(pll_cfg_pkg::ADDR_PUMP, 8'hFF);
        wr(15'h0086, 8'h5A);
        check_outputs();
        read_all();
        // frame cut short by chip select leaves the bank alone
        frame(1'b0, pll_cfg_pkg::ADDR_PUMP, 8'h01, 20);
        check_outputs();
        rd_chk(pll_cfg_pkg::ADDR_PUMP);
        // with clock enable low a whole write frame passes unseen
        ce_in = 1'b0;
        frame(1'b0, pll_cfg_pkg::ADDR_PUMP, 8'h2A, 24);
        ce_in = 1'b1;
        wait_clk(4);
        check_outputs();
        rd_chk(pll_cfg_pkg::ADDR_PUMP);
        // random traffic over mapped and unmapped bytes
        for (i = 0; i < 24; i++) begin
            seed = xorshift(seed);
            r = seed;
            wr(addrs[r[15:0] % 16'd7], r[31:24]);
            check_outputs();
            rd_chk(addrs[r[23:16] % 8'd7]);
        end
        // reset in mid-run restores every default
        rst_in = 1'b1;
        wait_clk(2);
        rst_in = 1'b0;
        model_reset();
        wait_clk(4);
        check_outputs();
        read_all();
        end_of_test();
    end
endmodule
`default_nettype wire
